// File: core/gpio_defines.svh
// Register offsets, reset values and pin positions of the pin controller
// Summary of operation
// - After reset every pin is an input, and each plain pin (function code 0) becomes an output through its own enable bit.
// - The pin-input register shows the present level of every pin, one bit per pin.
// - A plain pin (function code 0) whose enable bit is set is driven to the level of its output-value bit.
// - Separate set and clear registers change output bits without a read-modify-write.
// - The function selects are reset only by the device reset, never by the block's soft reset.
// - Each pin's function code takes its high bit from the second select and its low bit from the first; 0 is plain pin, 1 and 2 the first two functions.
// - When the straps choose management slave mode, the slave pins are taken over whatever the configuration says.
// - The processor straps are sampled at reset and the pins are free for normal use afterwards.
// - Every input is watched and its change flag is set whenever its value changes, except in the first cycle after a device or soft reset.
// - A change flag reaches the interrupt output only when its enable bit is set.
// - The identity view reads the AND of the change flags and the enables.
// - Six parallel signal-detect inputs, when enabled, replace the serial controller's value at the mapped port index.
`ifndef GPIO_DEFINES_SVH
`define GPIO_DEFINES_SVH
`define PIN_COUNT 22
`define SD_COUNT 6
`define SD_FIRST_PIN 10
`define STRAP_FIRST_PIN 18
`define SLV_MDC_PIN 14
`define SLV_MDIO_PIN 15
`define MIIM_SLAVE_STRAP 4'hF
`define OFF_OUT 8'h00
`define OFF_OUT_SET 8'h04
`define OFF_OUT_CLR 8'h08
`define OFF_IN 8'h0C
`define OFF_OE 8'h10
`define OFF_SEL0 8'h14
`define OFF_SEL1 8'h18
`define OFF_FLAGS 8'h1C
`define OFF_FLAG_CLR 8'h20
`define OFF_IRQ_ENA 8'h24
`define OFF_IDENT 8'h28
`define OFF_SD_MAP 8'h30
`define OFF_SD_LAST 8'h44
`define RST_PINS 22'h000000
`define RST_SD_INDEX 5'h00
`endif

// File: core/gpio_pkg.sv
// Types shared by the pin controller and its bench
package gpio_pkg;
  typedef struct packed {
    logic [7:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
  } apb_req_t;
  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;
  typedef enum logic [1:0] {FUNC_GPIO, FUNC_ALT1, FUNC_ALT2, FUNC_ALT3} func_code_t;
  typedef enum logic {BUS_IDLE, BUS_ANSWER} bus_state_t;
endpackage

// File: core/gpio_port.sv
// Pin controller: direction, output value, overlaid functions, change interrupt, signal detect
`timescale 1ns/10ps
`include "gpio_defines.svh"
module gpio_port (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic soft_rst,
  input wire gpio_pkg::apb_req_t apb_in,
  output gpio_pkg::apb_rsp_t apb_out,
  input wire logic [`PIN_COUNT-1:0] pin_in,
  output logic [`PIN_COUNT-1:0] pin_out,
  output logic [`PIN_COUNT-1:0] pin_oe,
  input wire logic [`PIN_COUNT-1:0] alt1_out,
  input wire logic [`PIN_COUNT-1:0] alt1_oe,
  input wire logic [`PIN_COUNT-1:0] alt2_out,
  input wire logic [`PIN_COUNT-1:0] alt2_oe,
  input wire logic [`PIN_COUNT-1:0] alt3_out,
  input wire logic [`PIN_COUNT-1:0] alt3_oe,
  input wire logic slave_mdio_out,
  input wire logic slave_mdio_oe,
  input wire logic [31:0] sio_signal_detect,
  output logic [31:0] signal_detect_out,
  output logic pin_irq,
  output logic [3:0] cpu_config_straps,
  output logic miim_slave_mode
);

  function automatic logic addr_is(logic [7:0] a, logic [7:0] off);
    return a == off;
  endfunction

  function automatic logic [31:0] widen(logic [`PIN_COUNT-1:0] v);
    return {10'h000, v};
  endfunction

  function automatic gpio_pkg::func_code_t func_code(logic [`PIN_COUNT-1:0] s1,
      logic [`PIN_COUNT-1:0] s0, int i);
    return gpio_pkg::func_code_t'({s1[i], s0[i]});
  endfunction

  gpio_pkg::bus_state_t bus_state_reg, bus_state_next;
  logic [`PIN_COUNT-1:0] out_reg, out_next;
  logic [`PIN_COUNT-1:0] oe_reg, oe_next;
  logic [`PIN_COUNT-1:0] sel0_reg, sel0_next;
  logic [`PIN_COUNT-1:0] sel1_reg, sel1_next;
  logic [`PIN_COUNT-1:0] flags_reg, flags_next;
  logic [`PIN_COUNT-1:0] ena_reg, ena_next;
  logic [`PIN_COUNT-1:0] prev_reg;
  logic prev_valid_reg;
  logic [4:0] sd_map_reg [`SD_COUNT];
  logic strap_pending_reg;
  logic [`PIN_COUNT-1:0] drv_out, drv_oe;
  logic [31:0] sd_next;

  wire [7:0] addr = apb_in.paddr;
  wire [`PIN_COUNT-1:0] wdata = apb_in.pwdata[`PIN_COUNT-1:0];
  wire bus_access = apb_in.psel & apb_in.penable;
  wire take = bus_access & (bus_state_reg == gpio_pkg::BUS_IDLE);
  wire fire = bus_access & (bus_state_reg == gpio_pkg::BUS_ANSWER);
  wire wr = fire & apb_in.pwrite;

  wire hit_out = addr_is(addr, `OFF_OUT);
  wire hit_set = addr_is(addr, `OFF_OUT_SET);
  wire hit_clr = addr_is(addr, `OFF_OUT_CLR);
  wire hit_in = addr_is(addr, `OFF_IN);
  wire hit_oe = addr_is(addr, `OFF_OE);
  wire hit_sel0 = addr_is(addr, `OFF_SEL0);
  wire hit_sel1 = addr_is(addr, `OFF_SEL1);
  wire hit_flags = addr_is(addr, `OFF_FLAGS);
  wire hit_fclr = addr_is(addr, `OFF_FLAG_CLR);
  wire hit_ena = addr_is(addr, `OFF_IRQ_ENA);
  wire hit_ident = addr_is(addr, `OFF_IDENT);
  wire [7:0] sd_off = addr - `OFF_SD_MAP;
  wire [2:0] sd_idx = sd_off[4:2];
  wire hit_sd = (addr >= `OFF_SD_MAP) && (addr <= `OFF_SD_LAST) && (addr[1:0] == 2'h0);
  wire mapped = hit_out | hit_set | hit_clr | hit_in | hit_oe | hit_sel0 | hit_sel1 |
    hit_flags | hit_fclr | hit_ena | hit_ident | hit_sd;

  wire [`PIN_COUNT-1:0] ident = flags_reg & ena_reg;
  // Write-only registers read as zero
  wire [31:0] rd_data =
    hit_out ? widen(out_reg) :
    hit_in ? widen(pin_in) :
    hit_oe ? widen(oe_reg) :
    hit_sel0 ? widen(sel0_reg) :
    hit_sel1 ? widen(sel1_reg) :
    hit_flags ? widen(flags_reg) :
    hit_ena ? widen(ena_reg) :
    hit_ident ? widen(ident) :
    hit_sd ? {27'h0000000, sd_map_reg[sd_idx]} : 32'h00000000;

  // Answer takes one wait cycle, so read data is registered with pready
  always_comb begin
    case (bus_state_reg)
      gpio_pkg::BUS_IDLE: bus_state_next = bus_access ? gpio_pkg::BUS_ANSWER : gpio_pkg::BUS_IDLE;
      gpio_pkg::BUS_ANSWER: bus_state_next = gpio_pkg::BUS_IDLE;
      default: bus_state_next = gpio_pkg::BUS_IDLE;
    endcase
  end

  wire [`PIN_COUNT-1:0] set_mask = (wr & hit_set) ? wdata : `RST_PINS;
  wire [`PIN_COUNT-1:0] clr_mask = (wr & hit_clr) ? wdata : `RST_PINS;
  assign out_next = ((wr & hit_out) ? wdata : out_reg) & ~clr_mask | set_mask;
  assign oe_next = (wr & hit_oe) ? wdata : oe_reg;
  assign sel0_next = (wr & hit_sel0) ? wdata : sel0_reg;
  assign sel1_next = (wr & hit_sel1) ? wdata : sel1_reg;
  assign ena_next = (wr & hit_ena) ? wdata : ena_reg;
  // No change is seen on the first cycle, so pins high at reset raise no flag
  wire [`PIN_COUNT-1:0] change = prev_valid_reg ? (pin_in ^ prev_reg) : `RST_PINS;
  wire [`PIN_COUNT-1:0] fclr_mask = (wr & hit_fclr) ? wdata : `RST_PINS;
  // A change in the clearing cycle keeps its flag
  assign flags_next = (flags_reg & ~fclr_mask) | change;

  always_comb begin
    drv_out = `RST_PINS;
    drv_oe = `RST_PINS;
    for (int i = 0; i < `PIN_COUNT; i++) begin
      case (func_code(sel1_reg, sel0_reg, i))
        gpio_pkg::FUNC_GPIO: begin
          drv_out[i] = out_reg[i];
          drv_oe[i] = oe_reg[i];
        end
        gpio_pkg::FUNC_ALT1: begin
          drv_out[i] = alt1_out[i];
          drv_oe[i] = alt1_oe[i];
        end
        gpio_pkg::FUNC_ALT2: begin
          drv_out[i] = alt2_out[i];
          drv_oe[i] = alt2_oe[i];
        end
        gpio_pkg::FUNC_ALT3: begin
          drv_out[i] = alt3_out[i];
          drv_oe[i] = alt3_oe[i];
        end
        default: begin
          drv_out[i] = 1'b0;
          drv_oe[i] = 1'b0;
        end
      endcase
    end
    if (miim_slave_mode) begin
      drv_oe[`SLV_MDC_PIN] = 1'b0;
      drv_out[`SLV_MDC_PIN] = 1'b0;
      drv_oe[`SLV_MDIO_PIN] = slave_mdio_oe;
      drv_out[`SLV_MDIO_PIN] = slave_mdio_out;
    end
  end

  always_comb begin
    sd_next = sio_signal_detect;
    for (int n = 0; n < `SD_COUNT; n++) begin
      if (func_code(sel1_reg, sel0_reg, `SD_FIRST_PIN + n) == gpio_pkg::FUNC_ALT3) begin
        sd_next[sd_map_reg[n]] = pin_in[`SD_FIRST_PIN + n];
      end
    end
  end

  // Selects follow only the device reset, so a soft reset keeps pin functions
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      sel0_reg <= `RST_PINS;
      sel1_reg <= `RST_PINS;
    end else begin
      sel0_reg <= sel0_next;
      sel1_reg <= sel1_next;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      out_reg <= `RST_PINS;
      oe_reg <= `RST_PINS;
      ena_reg <= `RST_PINS;
      flags_reg <= `RST_PINS;
      prev_valid_reg <= 1'b0;
    end else if (soft_rst) begin
      out_reg <= `RST_PINS;
      oe_reg <= `RST_PINS;
      ena_reg <= `RST_PINS;
      flags_reg <= `RST_PINS;
      prev_valid_reg <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg <= oe_next;
      ena_reg <= ena_next;
      flags_reg <= flags_next;
      prev_valid_reg <= 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int n = 0; n < `SD_COUNT; n++) sd_map_reg[n] <= `RST_SD_INDEX;
    end else if (soft_rst) begin
      for (int n = 0; n < `SD_COUNT; n++) sd_map_reg[n] <= `RST_SD_INDEX;
    end else if (wr & hit_sd) begin
      sd_map_reg[sd_idx] <= apb_in.pwdata[4:0];
    end
  end

  // Straps are caught at the first edge after release, while every pin is still an input
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      strap_pending_reg <= 1'b1;
      cpu_config_straps <= 4'h0;
      miim_slave_mode <= 1'b0;
    end else if (strap_pending_reg) begin
      strap_pending_reg <= 1'b0;
      cpu_config_straps <= pin_in[`STRAP_FIRST_PIN +: 4];
      miim_slave_mode <= (pin_in[`STRAP_FIRST_PIN +: 4] == `MIIM_SLAVE_STRAP);
    end
  end

  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      bus_state_reg <= gpio_pkg::BUS_IDLE;
      apb_out <= '0;
      prev_reg <= `RST_PINS;
      pin_out <= `RST_PINS;
      pin_oe <= `RST_PINS;
      pin_irq <= 1'b0;
      signal_detect_out <= 32'h00000000;
    end else begin
      bus_state_reg <= bus_state_next;
      apb_out.pready <= take;
      apb_out.pslverr <= take & ~mapped;
      apb_out.prdata <= (take & ~apb_in.pwrite) ? rd_data : 32'h00000000;
      prev_reg <= pin_in;
      pin_out <= drv_out;
      pin_oe <= drv_oe;
      pin_irq <= |(flags_reg & ena_reg);
      signal_detect_out <= sd_next;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  a_plain_oe_write: assert property ((wr && hit_oe && sel0_reg == 0 && sel1_reg == 0
      && !miim_slave_mode && !soft_rst) |=> ##1 pin_oe == $past(wdata, 2))
    else $error("Output enable write did not reach plain pins");
  a_pin_read: assert property ((take && hit_in && !apb_in.pwrite)
      |=> apb_out.pready && apb_out.prdata == widen($past(pin_in)))
    else $error("Pin read returned wrong value");
  a_set_bits: assert property ((wr && hit_set && !soft_rst)
      |=> out_reg == ($past(out_reg) | $past(wdata)))
    else $error("Atomic set changed wrong bits");
  a_clear_bits: assert property ((wr && hit_clr && !soft_rst)
      |=> out_reg == ($past(out_reg) & ~$past(wdata)))
    else $error("Atomic clear changed wrong bits");
  a_select_soft_keep: assert property (soft_rst
      |=> sel0_reg == $past(sel0_reg) && sel1_reg == $past(sel1_reg))
    else $error("Soft reset disturbed function selects");
  a_change_flag_set: assert property ((change != 0 && !soft_rst)
      |=> (flags_reg & $past(change)) == $past(change))
    else $error("Input change left no flag");
  a_flag_hold: assert property ((!soft_rst && !(wr && hit_fclr))
      |=> (flags_reg & $past(flags_reg)) == $past(flags_reg))
    else $error("Change flag dropped without a clear");
  a_irq_gated: assert property (((flags_reg & ena_reg) == 0) [*2] |-> !pin_irq)
    else $error("Interrupt raised with no enabled flag");
  a_ident_read: assert property ((take && hit_ident && !apb_in.pwrite)
      |=> apb_out.prdata == widen($past(flags_reg & ena_reg)))
    else $error("Identity view is not flags AND enables");
  a_sd_override: assert property ((func_code(sel1_reg, sel0_reg, `SD_FIRST_PIN)
      == gpio_pkg::FUNC_ALT3) |=> signal_detect_out[$past(sd_map_reg[0])] ==
      $past(pin_in[`SD_FIRST_PIN]))
    else $error("Signal detect 0 did not override its port");
  a_strap_catch: assert property ((strap_pending_reg && !sys_rst)
      |=> cpu_config_straps == $past(pin_in[`STRAP_FIRST_PIN +: 4]) && !strap_pending_reg)
    else $error("Straps not caught after reset");

  c_set_write: cover property (wr && hit_set);
  c_flag_irq: cover property (change != 0 ##[1:4] pin_irq);
  c_sd_active: cover property (func_code(sel1_reg, sel0_reg, `SD_FIRST_PIN)
      == gpio_pkg::FUNC_ALT3);
  c_bad_addr: cover property (apb_out.pready && apb_out.pslverr);

endmodule // gpio_port

// File: tb/pin_world.sv
// Board-side model of the pins: external drivers meet the block's own drive
`timescale 1ns/10ps
module pin_world (
  input wire logic [21:0] pin_out,
  input wire logic [21:0] pin_oe,
  input wire logic [21:0] ext_level,
  output logic [21:0] pin_in
);
  // Board drivers are resistive, so an enabled block driver always wins the wire
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule // pin_world

// File: tb/testbench.sv
// Self-checking bench for the pin controller
`timescale 1ns/10ps
`include "gpio_defines.svh"
`define CHK(n, e, s) chk(n, 32'(e), 32'(s))
module testbench;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic soft_rst = 1'b0;
  gpio_pkg::apb_req_t req = '0;
  gpio_pkg::apb_rsp_t rsp;
  logic [21:0] ext = 22'h140000;
  logic [21:0] pin_in, pin_out, pin_oe, a1o, a1e, a2o, a2e, a3o, a3e, ov, m, sm;
  logic mo, me, irq, slv, er, v;
  logic [31:0] sio, sd_out, rd, o, e, s, c, p;
  logic [31:0] st = 32'h00002CC2;
  logic [3:0] straps;
  int n_mismatch = 0;
  int tests_run = 0;
  gpio_port DUT (.core_clk(core_clk), .sys_rst(sys_rst), .soft_rst(soft_rst), .apb_in(req),
    .apb_out(rsp), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .alt1_out(a1o),
    .alt1_oe(a1e), .alt2_out(a2o), .alt2_oe(a2e), .alt3_out(a3o), .alt3_oe(a3e),
    .slave_mdio_out(mo), .slave_mdio_oe(me), .sio_signal_detect(sio),
    .signal_detect_out(sd_out), .pin_irq(irq), .cpu_config_straps(straps),
    .miim_slave_mode(slv));
  pin_world board (.pin_out(pin_out), .pin_oe(pin_oe), .ext_level(ext), .pin_in(pin_in));
  always #5 core_clk = ~core_clk;
  function logic [31:0] xs();
    st ^= st << 13;
    st ^= st >> 17;
    st ^= st << 5;
    return st;
  endfunction
  // Expected {enable, gated drive} of pin 4 for a function code
  function automatic logic [1:0] fexp(input logic [1:0] fc);
    case (fc)
      2'h0: return {1'b1, ov[4]};
      2'h1: return {a1e[4], a1o[4] & a1e[4]};
      2'h2: return {a2e[4], a2o[4] & a2e[4]};
      default: return {a3e[4], a3o[4] & a3e[4]};
    endcase
  endfunction
  task close_out();
    $display("Mismatches %0d in %0d checks", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task chk(input string nm, input logic [31:0] ex, input logic [31:0] sn);
    tests_run++;
    if (ex !== sn) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, ex, sn);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int k;
    @(posedge core_clk);
    req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while (rsp.pready !== 1'b1 && k < 20);
    rd = rsp.prdata;
    er = rsp.pslverr;
    req <= '0;
    if (rsp.pready !== 1'b1) begin
      n_mismatch++;
      $display("BAD pready expected 1 seen %b", rsp.pready);
      close_out();
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(a, 1'b0, 32'h0);
    `CHK(nm, ex, rd);
  endtask
  task set_alts();
    {a1o, a1e, a2o, a2e} <= {xs(), xs(), xs()};
    {a3o, a3e} <= {xs(), xs()};
  endtask
  initial begin
    {a1o, a1e, a2o, a2e, a3o, a3e, mo, me, sio} = '0;
    repeat (5) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    `CHK("straps", 4'h5, straps);
    `CHK("pin_oe after reset", 22'h0, pin_oe);
    rd_chk("oe reg", `OFF_OE, 32'h0);
    repeat (6) begin
      {o, e, s, c} = {xs(), xs(), xs(), xs()};
      wr(`OFF_OUT, o);
      wr(`OFF_OE, e);
      wr(`OFF_OUT_SET, s);
      wr(`OFF_OUT_CLR, c);
      ov = (o[21:0] | s[21:0]) & ~c[21:0];
      rd_chk("out reg", `OFF_OUT, ov);
      `CHK("pin_oe", e[21:0], pin_oe);
      `CHK("pin_out", ov & e[21:0], pin_out & pin_oe);
      rd_chk("pin in", `OFF_IN, (ov & e[21:0]) | (ext & ~e[21:0]));
    end
    wr(`OFF_OE, 32'h0);
    for (int k = 0; k < 2; k++) begin
      wr(`OFF_FLAG_CLR, 32'h003FFFFF);
      rd_chk("flags idle", `OFF_FLAGS, 32'h0);
      m = xs();
      wr(`OFF_IRQ_ENA, k == 0 ? m : ~m);
      ext <= ext ^ m;
      repeat (4) @(posedge core_clk);
      rd_chk("flags", `OFF_FLAGS, m);
      rd_chk("identity", `OFF_IDENT, k == 0 ? m : 22'h0);
      `CHK("irq", k == 0 && m != 0, irq);
      wr(`OFF_FLAG_CLR, m);
      rd_chk("flags cleared", `OFF_FLAGS, 32'h0);
      `CHK("irq cleared", 1'b0, irq);
    end
    wr(`OFF_OE, 32'h10);
    for (int fc = 0; fc < 4; fc++) begin
      set_alts();
      wr(`OFF_SEL0, {27'h0000000, fc[0], 4'h0});
      wr(`OFF_SEL1, {27'h0000000, fc[1], 4'h0});
      repeat (2) @(posedge core_clk);
      `CHK("pin 4 function", fexp(fc[1:0]), {pin_oe[4], pin_out[4] & pin_oe[4]});
    end
    soft_rst <= 1'b1;
    @(posedge core_clk);
    soft_rst <= 1'b0;
    rd_chk("sel0 kept", `OFF_SEL0, 32'h10);
    rd_chk("sel1 kept", `OFF_SEL1, 32'h10);
    rd_chk("out after soft reset", `OFF_OUT, 32'h0);
    // Code 3 also hands signal detect pins to the third function, so its enables are cleared to keep them inputs
    {a3o, a3e} <= '0;
    sm = '0;
    for (int n = 0; n < 6; n++) begin
      p = n * 5 + xs() % 5;
      // Map entry is written before the pin is handed to signal detect
      wr(`OFF_SD_MAP + 8'(4 * n), p);
      rd_chk("map entry", `OFF_SD_MAP + 8'(4 * n), p);
      sm[10 + n] = 1'b1;
      wr(`OFF_SEL0, sm);
      wr(`OFF_SEL1, sm);
      for (int t = 0; t < 2; t++) begin
        v = xs() % 2;
        ext[10 + n] <= v;
        sio <= t ? ~{32{v}} : xs();
        repeat (4) @(posedge core_clk);
        `CHK("signal detect", v, sd_out[p]);
      end
    end
    apb(8'h2C, 1'b0, 32'h0);
    `CHK("unmapped error", 1'b1, er);
    `CHK("unmapped data", 32'h00000000, rd);
    {mo, me} <= {xs()} % 4;
    ext <= ext | 22'h3C0000;
    sys_rst <= 1'b1;
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK("slave mode", 1'b1, slv);
    `CHK("slave data", {me, mo & me}, {pin_oe[15], pin_out[15] & pin_oe[15]});
    close_out();
  end
endmodule // testbench
